// File: dcv_defines.svh
// Register offsets, field positions, reset values and timing counts of the CVD control block
`ifndef DCV_DEFINES_SVH
`define DCV_DEFINES_SVH

`define DCV_ADDR_W 4
`define DCV_OFF_SEC2 4'h0
`define DCV_OFF_COMMON 4'h1
`define DCV_OFF_TRIG1 4'h2
`define DCV_OFF_TRIG2 4'h3
`define DCV_OFF_POL1 4'h4
`define DCV_OFF_POL2 4'h5
`define DCV_OFF_STAT 4'h6
`define DCV_OFF_CTRL1 4'h7
`define DCV_OFF_CTRL2 4'h8
`define DCV_OFF_PRE1 4'h9
`define DCV_OFF_PRE2 4'ha
`define DCV_OFF_RES1H 4'hb
`define DCV_OFF_RES1L 4'hc
`define DCV_OFF_RES2H 4'hd
`define DCV_OFF_RES2L 4'he

`define DCV_RST_BYTE 8'h00

`define DCV_JUSTIFY_BIT 7
`define DCV_CLKSEL_MSB 6
`define DCV_CLKSEL_LSB 4
`define DCV_GOALL_BIT 2
`define DCV_PREF_MSB 1
`define DCV_PREF_LSB 0
`define DCV_TRIG_MSB 6
`define DCV_TRIG_LSB 4
`define DCV_EPPOL_BIT 7
`define DCV_IPPOL_BIT 6
`define DCV_IPEN_BIT 1
`define DCV_DSEN_BIT 0
`define DCV_EN_BIT 0
`define DCV_START_BIT 1
`define DCV_PRE_MSB 6
`define DCV_SEC_MSB 6
`define DCV_CONV2_FLAG_BIT 6
`define DCV_CONV1_FLAG_BIT 2

`define DCV_PRIMARY_SEC_IN_TWENTY 5'h14
`define DCV_INSTR_CLKS 10'd4
`define DCV_CLK_PERIOD_NS 25
`define DCV_ACQ_TIME_NS 1000
`define DCV_ACQ_CYCLES ((`DCV_ACQ_TIME_NS + `DCV_CLK_PERIOD_NS - 1) / `DCV_CLK_PERIOD_NS)
`define DCV_CONV_TICKS 10'd11

`endif

// File: dcv_pkg.sv
// Types shared by the CVD control block
`default_nettype none
package dcv_pkg;

  typedef enum logic [1:0] {
    DCV_IDLE = 2'b00,
    DCV_PRE = 2'b01,
    DCV_ACQ = 2'b10,
    DCV_CONV = 2'b11
  } dcv_stage_t;

  typedef enum logic [2:0] {
    DCV_TRG_NONE = 3'b000,
    DCV_TRG_RSV1 = 3'b001,
    DCV_TRG_RSV2 = 3'b010,
    DCV_TRG_TMR0 = 3'b011,
    DCV_TRG_TMR1 = 3'b100,
    DCV_TRG_TMR2 = 3'b101,
    DCV_TRG_RISE = 3'b110,
    DCV_TRG_FALL = 3'b111
  } dcv_trig_t;

  typedef struct packed {
    dcv_stage_t stage;
    logic ext_pol;
    logic int_pol;
    logic guard_pol;
    logic second;
  } dcv_analog_t;

  typedef struct packed {
    logic [2:0] conv_clock_sel;
    logic rc_select;
    logic [1:0] pos_ref_sel;
  } dcv_common_t;

endpackage : dcv_pkg
`default_nettype wire

// File: dcv_ctrl.sv
// Control and status logic of the two hardware CVD converter channels
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dcv_defines.svh"

module dcv_ctrl (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TMR0_OVF,
  input wire logic TMR1_OVF,
  input wire logic TMR2_MATCH,
  input wire logic TRIG_PIN,
  input wire logic RC_TICK,
  input wire logic [4:0] PRI_CH2,
  input wire logic [1:0] GUARD_POL_SET,
  input wire logic [9:0] CORE_RESULT1,
  input wire logic [9:0] CORE_RESULT2,
  output dcv_pkg::dcv_analog_t ANALOG1,
  output dcv_pkg::dcv_analog_t ANALOG2,
  output dcv_pkg::dcv_common_t COMMON,
  output logic CONV_TICK,
  output logic [1:0] CONV_ENABLE,
  output logic [6:0] SEC2_CONNECT,
  output logic [6:0] SEC2_PRECHARGE,
  output logic [6:0] SEC2_PIN_DIRECTION_FORCE
);
  import dcv_pkg::*;

  localparam logic [9:0] ACQ_CYC = 10'(`DCV_ACQ_CYCLES);

  logic [6:0] sec2_reg;
  logic justify_reg;
  logic [2:0] clk_sel_reg;
  logic [1:0] pref_reg;
  logic [2:0] trig_reg [2];
  logic [7:0] pol_reg [2];
  logic [6:0] pre_reg [2];
  logic [1:0] en_reg;
  logic [1:0] en_next;
  logic [1:0] start_reg;
  logic [1:0] start_next;
  logic [1:0] pair_reg;
  dcv_stage_t stage_reg [2];
  logic [9:0] cnt_reg [2];
  logic [15:0] res_reg [2];
  logic [5:0] div_reg;
  logic [5:0] div_mask;
  logic rc_sel;
  logic tick;
  logic trig_prev_reg;
  logic [1:0] done;
  logic [1:0] auto_ev;
  logic wr_common_go;
  logic [7:0] rd_next;

  function automatic logic [5:0] div_mask_f(input logic [2:0] sel);
    case (sel)
      3'b000: div_mask_f = 6'h01;
      3'b001: div_mask_f = 6'h07;
      3'b010: div_mask_f = 6'h1f;
      3'b100: div_mask_f = 6'h03;
      3'b101: div_mask_f = 6'h0f;
      3'b110: div_mask_f = 6'h3f;
      default: div_mask_f = 6'h00;
    endcase
  endfunction : div_mask_f

  // Register writes; status register is hardware owned, writes to it are dropped
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sec2_reg <= 7'h00;
      justify_reg <= 1'b0;
      clk_sel_reg <= 3'h0;
      pref_reg <= 2'h0;
      trig_reg[0] <= 3'h0;
      trig_reg[1] <= 3'h0;
      pol_reg[0] <= `DCV_RST_BYTE;
      pol_reg[1] <= `DCV_RST_BYTE;
      pre_reg[0] <= 7'h00;
      pre_reg[1] <= 7'h00;
      en_reg <= 2'b00;
    end
    else
    begin
      en_reg <= en_next;
      if (WR)
      begin
        case (ADDR)
          `DCV_OFF_SEC2: sec2_reg <= WDATA[`DCV_SEC_MSB:0];
          `DCV_OFF_COMMON:
          begin
            justify_reg <= WDATA[`DCV_JUSTIFY_BIT];
            clk_sel_reg <= WDATA[`DCV_CLKSEL_MSB:`DCV_CLKSEL_LSB];
            pref_reg <= WDATA[`DCV_PREF_MSB:`DCV_PREF_LSB];
          end
          `DCV_OFF_TRIG1: trig_reg[0] <= WDATA[`DCV_TRIG_MSB:`DCV_TRIG_LSB];
          `DCV_OFF_TRIG2: trig_reg[1] <= WDATA[`DCV_TRIG_MSB:`DCV_TRIG_LSB];
          `DCV_OFF_POL1: pol_reg[0] <= WDATA & 8'hc3;
          `DCV_OFF_POL2: pol_reg[1] <= WDATA & 8'hc3;
          `DCV_OFF_PRE1: pre_reg[0] <= WDATA[`DCV_PRE_MSB:0];
          `DCV_OFF_PRE2: pre_reg[1] <= WDATA[`DCV_PRE_MSB:0];
          default: ;
        endcase
      end
    end
  end

  always_comb
  begin
    en_next = en_reg;
    if (WR && ADDR == `DCV_OFF_CTRL1)
      en_next[0] = WDATA[`DCV_EN_BIT];
    if (WR && ADDR == `DCV_OFF_CTRL2)
      en_next[1] = WDATA[`DCV_EN_BIT];
  end

  // Free-running divider; the RC codes take the external RC tick instead
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      div_reg <= 6'h00;
    else
      div_reg <= div_reg + 6'h01;
  end

  assign rc_sel = (clk_sel_reg[1:0] == 2'b11);
  assign div_mask = div_mask_f(clk_sel_reg);
  assign tick = rc_sel ? RC_TICK : ((div_reg & div_mask) == div_mask);

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= TRIG_PIN;
  end

  assign wr_common_go = WR && ADDR == `DCV_OFF_COMMON && WDATA[`DCV_GOALL_BIT];

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_conv
      logic ds;
      logic inv;
      logic [9:0] pre_cnt;
      logic [9:0] raw;
      logic wr_ctrl;

      assign ds = pol_reg[c][`DCV_DSEN_BIT];
      assign inv = pol_reg[c][`DCV_IPEN_BIT] & ds & pair_reg[c];
      assign pre_cnt = 10'(pre_reg[c]) * `DCV_INSTR_CLKS - 10'd1;
      assign raw = (c == 0) ? CORE_RESULT1 : CORE_RESULT2;
      assign wr_ctrl = WR && ADDR == ((c == 0) ? `DCV_OFF_CTRL1 : `DCV_OFF_CTRL2);

      // Reserved trigger codes act as no trigger
      always_comb
      begin
        case (dcv_trig_t'(trig_reg[c]))
          DCV_TRG_TMR0: auto_ev[c] = TMR0_OVF;
          DCV_TRG_TMR1: auto_ev[c] = TMR1_OVF;
          DCV_TRG_TMR2: auto_ev[c] = TMR2_MATCH;
          DCV_TRG_RISE: auto_ev[c] = TRIG_PIN & ~trig_prev_reg;
          DCV_TRG_FALL: auto_ev[c] = ~TRIG_PIN & trig_prev_reg;
          default: auto_ev[c] = 1'b0;
        endcase
      end

      assign done[c] = stage_reg[c] == DCV_CONV && tick && cnt_reg[c] == 10'd0 &&
                       !(ds && !pair_reg[c]);

      // A new start arriving with completion wins, so back-to-back triggers are kept
      always_comb
      begin
        start_next[c] = start_reg[c];
        if (!en_next[c])
          start_next[c] = 1'b0;
        else if (wr_common_go || auto_ev[c] || (wr_ctrl && WDATA[`DCV_START_BIT]))
          start_next[c] = 1'b1;
        else if (done[c] || wr_ctrl)
          start_next[c] = 1'b0;
      end

      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
          start_reg[c] <= 1'b0;
        else
          start_reg[c] <= start_next[c];
      end

      // Sequencer; clearing start mid-run aborts back to idle
      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          stage_reg[c] <= DCV_IDLE;
          cnt_reg[c] <= 10'd0;
          pair_reg[c] <= 1'b0;
        end
        else if (!start_reg[c])
        begin
          stage_reg[c] <= DCV_IDLE;
          pair_reg[c] <= 1'b0;
          cnt_reg[c] <= 10'd0;
        end
        else
        begin
          case (stage_reg[c])
            DCV_IDLE:
            begin
              pair_reg[c] <= 1'b0;
              if (pre_reg[c] != 7'h00)
              begin
                stage_reg[c] <= DCV_PRE;
                cnt_reg[c] <= pre_cnt;
              end
              else
              begin
                stage_reg[c] <= DCV_ACQ;
                cnt_reg[c] <= ACQ_CYC - 10'd1;
              end
            end
            DCV_PRE:
              if (cnt_reg[c] == 10'd0)
              begin
                stage_reg[c] <= DCV_ACQ;
                cnt_reg[c] <= ACQ_CYC - 10'd1;
              end
              else
                cnt_reg[c] <= cnt_reg[c] - 10'd1;
            DCV_ACQ:
              if (cnt_reg[c] == 10'd0)
              begin
                stage_reg[c] <= DCV_CONV;
                cnt_reg[c] <= `DCV_CONV_TICKS - 10'd1;
              end
              else
                cnt_reg[c] <= cnt_reg[c] - 10'd1;
            DCV_CONV:
              if (tick && cnt_reg[c] == 10'd0)
              begin
                if (ds && !pair_reg[c])
                begin
                  pair_reg[c] <= 1'b1;
                  if (pre_reg[c] != 7'h00)
                  begin
                    stage_reg[c] <= DCV_PRE;
                    cnt_reg[c] <= pre_cnt;
                  end
                  else
                  begin
                    stage_reg[c] <= DCV_ACQ;
                    cnt_reg[c] <= ACQ_CYC - 10'd1;
                  end
                end
                else
                begin
                  stage_reg[c] <= DCV_IDLE;
                  pair_reg[c] <= 1'b0;
                end
              end
              else if (tick)
                cnt_reg[c] <= cnt_reg[c] - 10'd1;
            default: stage_reg[c] <= DCV_IDLE;
          endcase
        end
      end

      // Result captured at the end of each conversion in the chosen justification
      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
          res_reg[c] <= 16'h0000;
        else if (start_reg[c] && stage_reg[c] == DCV_CONV && tick && cnt_reg[c] == 10'd0)
          res_reg[c] <= justify_reg ? {6'h00, raw} : {raw, 6'h00};
      end
    end
  endgenerate

  // Inversion only touches what the converter sees, the stored bits stay put
  assign ANALOG1.stage = stage_reg[0];
  assign ANALOG1.ext_pol = pol_reg[0][`DCV_EPPOL_BIT] ^ g_conv[0].inv;
  assign ANALOG1.int_pol = pol_reg[0][`DCV_IPPOL_BIT] ^ g_conv[0].inv;
  assign ANALOG1.guard_pol = GUARD_POL_SET[0] ^ g_conv[0].inv;
  assign ANALOG1.second = pair_reg[0];
  assign ANALOG2.stage = stage_reg[1];
  assign ANALOG2.ext_pol = pol_reg[1][`DCV_EPPOL_BIT] ^ g_conv[1].inv;
  assign ANALOG2.int_pol = pol_reg[1][`DCV_IPPOL_BIT] ^ g_conv[1].inv;
  assign ANALOG2.guard_pol = GUARD_POL_SET[1] ^ g_conv[1].inv;
  assign ANALOG2.second = pair_reg[1];

  assign COMMON.conv_clock_sel = clk_sel_reg;
  assign COMMON.rc_select = rc_sel;
  assign COMMON.pos_ref_sel = pref_reg;
  assign CONV_TICK = tick;
  assign CONV_ENABLE = en_reg;

  genvar s;
  generate
    for (s = 0; s < 7; s++)
    begin : g_sec
      logic is_primary;
      assign is_primary = PRI_CH2 == `DCV_PRIMARY_SEC_IN_TWENTY + 5'(s);
      assign SEC2_CONNECT[s] = en_reg[1] & sec2_reg[s] & ~is_primary;
      assign SEC2_PIN_DIRECTION_FORCE[s] = en_reg[1] & sec2_reg[s];
      assign SEC2_PRECHARGE[s] = SEC2_CONNECT[s] & (stage_reg[1] == DCV_PRE);
    end
  endgenerate

  // Read data is registered and stands one cycle after the strobe
  always_comb
  begin
    rd_next = 8'h00;
    case (ADDR)
      `DCV_OFF_SEC2: rd_next = {1'b0, sec2_reg};
      `DCV_OFF_COMMON: rd_next = {justify_reg, clk_sel_reg, 1'b0, |start_reg, pref_reg};
      `DCV_OFF_TRIG1: rd_next = {1'b0, trig_reg[0], 4'h0};
      `DCV_OFF_TRIG2: rd_next = {1'b0, trig_reg[1], 4'h0};
      `DCV_OFF_POL1: rd_next = pol_reg[0];
      `DCV_OFF_POL2: rd_next = pol_reg[1];
      `DCV_OFF_STAT: rd_next = {1'b0, pair_reg[1], stage_reg[1], 1'b0, pair_reg[0],
                                stage_reg[0]};
      `DCV_OFF_CTRL1: rd_next = {6'h00, start_reg[0], en_reg[0]};
      `DCV_OFF_CTRL2: rd_next = {6'h00, start_reg[1], en_reg[1]};
      `DCV_OFF_PRE1: rd_next = {1'b0, pre_reg[0]};
      `DCV_OFF_PRE2: rd_next = {1'b0, pre_reg[1]};
      `DCV_OFF_RES1H: rd_next = res_reg[0][15:8];
      `DCV_OFF_RES1L: rd_next = res_reg[0][7:0];
      `DCV_OFF_RES2H: rd_next = res_reg[1][15:8];
      `DCV_OFF_RES2L: rd_next = res_reg[1][7:0];
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rd_next;
    else
      RDATA <= 8'h00;
  end

endmodule : dcv_ctrl
`default_nettype wire

// File: dcv_ctrl_properties.sv
// Port assertions of the CVD control block
`timescale 1ns/1ps
`default_nettype none
module dcv_ctrl_properties (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [4:0] PRI_CH2,
  input wire logic [1:0] GUARD_POL_SET,
  input wire logic [1:0] CONV_ENABLE,
  input wire logic [6:0] SEC2_CONNECT,
  input wire logic [6:0] SEC2_PRECHARGE,
  input wire logic [6:0] SEC2_PIN_DIRECTION_FORCE,
  input wire dcv_pkg::dcv_analog_t ANALOG1,
  input wire dcv_pkg::dcv_analog_t ANALOG2
);
  import dcv_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  property p_sec_en;
    SEC2_CONNECT != 7'h00 |-> CONV_ENABLE[1];
  endproperty
  a_sec_en: assert property (p_sec_en) else $error("switch closed while off");
  property p_pin_direction_en;
    SEC2_PIN_DIRECTION_FORCE != 7'h00 |-> CONV_ENABLE[1];
  endproperty
  a_pin_direction_en: assert property (p_pin_direction_en) else $error("driver forced while off");
  property p_bias;
    SEC2_PRECHARGE == (SEC2_CONNECT & {7{ANALOG2.stage == DCV_PRE}});
  endproperty
  a_bias: assert property (p_bias) else $error("secondary bias wrong");
  property p_primary;
    (PRI_CH2 >= 5'h14 && PRI_CH2 <= 5'h1a) |-> !SEC2_CONNECT[PRI_CH2 - 5'h14];
  endproperty
  a_primary: assert property (p_primary) else $error("primary also secondary");
  property p_pin_direction;
    (SEC2_CONNECT & ~SEC2_PIN_DIRECTION_FORCE) == 7'h00;
  endproperty
  a_pin_direction: assert property (p_pin_direction) else $error("connected pin still driven");
  property p_pre_next;
    ANALOG1.stage == DCV_PRE |=> ANALOG1.stage inside {DCV_PRE, DCV_ACQ, DCV_IDLE};
  endproperty
  a_pre_next: assert property (p_pre_next) else $error("stage order broken");
  // Fixed 40-clock acquisition, then straight into conversion
  property p_acq_len;
    $rose(ANALOG1.stage == DCV_ACQ) |-> ##39 ANALOG1.stage == DCV_ACQ
      ##1 ANALOG1.stage == DCV_CONV;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");
  property p_guard;
    (ANALOG1.stage != DCV_IDLE && !ANALOG1.second) |-> ANALOG1.guard_pol == GUARD_POL_SET[0];
  endproperty
  a_guard: assert property (p_guard) else $error("first pass guard flipped");
  c_second: cover property (ANALOG2.second && ANALOG2.stage == DCV_PRE);
  c_acq: cover property ($rose(ANALOG1.stage == DCV_ACQ));
  c_sec: cover property (SEC2_CONNECT != 7'h00);
endmodule : dcv_ctrl_properties
bind dcv_ctrl dcv_ctrl_properties u_props (.CLOCK, .RSTN, .PRI_CH2, .GUARD_POL_SET,
  .CONV_ENABLE, .SEC2_CONNECT, .SEC2_PRECHARGE, .SEC2_PIN_DIRECTION_FORCE, .ANALOG1, .ANALOG2);
`default_nettype wire

// File: dcv_core_model.sv
// Model of the analog converter core and its RC oscillator
`timescale 1ns/1ps
`default_nettype none
module dcv_core_model #(
  parameter int RC_DIV = 3,
  parameter logic [9:0] RES_A = 10'h2c9,
  parameter logic [9:0] RES_B = 10'h137
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire dcv_pkg::dcv_analog_t ANALOG1,
  input wire dcv_pkg::dcv_analog_t ANALOG2,
  output logic RC_TICK,
  output logic [9:0] CORE_RESULT1,
  output logic [9:0] CORE_RESULT2
);
  import dcv_pkg::*;
  logic [7:0] rc_cnt_reg;
  always_ff @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
      rc_cnt_reg <= 8'h00;
    else
      rc_cnt_reg <= (rc_cnt_reg == 8'(RC_DIV - 1)) ? 8'h00 : rc_cnt_reg + 8'h01;
  assign RC_TICK = (rc_cnt_reg == 8'h00);
  // Outside conversion the core shows the inverse, so a sample taken late is seen
  function automatic logic [9:0] res_of(input dcv_analog_t a);
    return (a.stage == DCV_CONV) ? (a.second ? RES_B : RES_A) : ~RES_A;
  endfunction : res_of
  assign CORE_RESULT1 = res_of(ANALOG1);
  assign CORE_RESULT2 = res_of(ANALOG2);
endmodule : dcv_core_model
`default_nettype wire

// File: dcv_ctrl_tb_top.sv
// Self-checking testbench of the CVD control block
`timescale 1ns/1ps
`default_nettype none
`include "dcv_defines.svh"
module dcv_ctrl_tb_top;
  import dcv_pkg::*;
  localparam logic [9:0] RES_A = 10'h2c9;
  localparam logic [9:0] RES_B = 10'h137;
  logic clock = 1'b0;
  logic rstn, wr_s, rd_s, tmr0, tmr1, tmr2, trig_pin, rc_tick, conv_tick;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [4:0] pri_ch2;
  logic [1:0] guard_set, conv_en;
  logic [9:0] res1, res2;
  logic [6:0] sec_con, sec_pre, sec_pin_direction;
  logic [15:0] seed;
  dcv_analog_t an1, an2;
  dcv_common_t common;
  int err_total = 0;
  int n_checks = 0;
  int waited;
  int ticks, rc_n;
  logic [3:0] offs [9] = '{`DCV_OFF_SEC2, `DCV_OFF_TRIG1, `DCV_OFF_TRIG2, `DCV_OFF_POL1,
    `DCV_OFF_POL2, `DCV_OFF_PRE1, `DCV_OFF_PRE2, `DCV_OFF_STAT, 4'hf};
  logic [7:0] msk [9] = '{8'h7f, 8'h70, 8'h70, 8'hc3, 8'hc3, 8'h7f, 8'h7f, 8'h00, 8'h00};
  always #12.5 clock = ~clock;
  dcv_ctrl u_dut (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .TMR0_OVF(tmr0), .TMR1_OVF(tmr1), .TMR2_MATCH(tmr2),
    .TRIG_PIN(trig_pin), .RC_TICK(rc_tick), .PRI_CH2(pri_ch2), .GUARD_POL_SET(guard_set),
    .CORE_RESULT1(res1), .CORE_RESULT2(res2), .ANALOG1(an1), .ANALOG2(an2),
    .COMMON(common), .CONV_TICK(conv_tick), .CONV_ENABLE(conv_en), .SEC2_CONNECT(sec_con),
    .SEC2_PRECHARGE(sec_pre), .SEC2_PIN_DIRECTION_FORCE(sec_pin_direction));
  dcv_core_model #(.RC_DIV(3), .RES_A(RES_A), .RES_B(RES_B)) u_core (.CLOCK(clock),
    .RSTN(rstn), .ANALOG1(an1), .ANALOG2(an2), .RC_TICK(rc_tick), .CORE_RESULT1(res1),
    .CORE_RESULT2(res2));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Conversion clock divisor per select code; RC codes are counted against the RC tick
  function automatic int clk_div(input logic [2:0] sel);
    case (sel)
      3'b000: return 2;
      3'b001: return 8;
      3'b010: return 32;
      3'b100: return 4;
      3'b101: return 16;
      3'b110: return 64;
      default: return 1;
    endcase
  endfunction : clk_div
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1;
    chk(what, 16'(rdata), 16'(exp));
  endtask : rd
  // Bounded: a stuck sequencer ends the run instead of hanging it
  task automatic wait_for(input int n, input dcv_stage_t s, input logic sec);
    dcv_analog_t a;
    waited = 0;
    a = (n == 1) ? an1 : an2;
    while (!(a.stage === s && a.second === sec))
    begin
      @(posedge clock);
      #1;
      waited++;
      a = (n == 1) ? an1 : an2;
      if (waited > 3000)
      begin
        chk("stage wait", 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
  endtask : wait_for
  task automatic fire(input int s);
    @(posedge clock);
    tmr0 <= (s == 0);
    tmr1 <= (s == 1);
    tmr2 <= (s == 2);
    if (s >= 3)
      trig_pin <= (s == 3);
    @(posedge clock);
    {tmr0, tmr1, tmr2} <= 3'b000;
  endtask : fire
  initial
  begin
    {rstn, wr_s, rd_s, tmr0, tmr1, tmr2, trig_pin} = 7'h00;
    addr = 4'h0;
    wdata = 8'h00;
    pri_ch2 = 5'h00;
    guard_set = 2'b10;
    seed = 16'h1a7e;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++)
      rd(4'(i), 8'h00, "reset");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(`DCV_OFF_COMMON, {seed[0], 3'(i), 2'b00, 2'(i)});
      chk("clksel", 16'(common.conv_clock_sel), 16'(i[2:0]));
      chk("rcsel", 16'(common.rc_select), 16'(i[1:0] == 2'b11));
      chk("ref", 16'(common.pos_ref_sel), 16'(i[1:0]));
      rd(`DCV_OFF_COMMON, {seed[0], 3'(i), 2'b00, 2'(i)}, "common");
      ticks = 0;
      rc_n = 0;
      repeat (64)
      begin
        @(posedge clock);
        #1;
        ticks += int'(conv_tick);
        rc_n += int'(rc_tick);
      end
      chk("ticks", 16'(ticks), 16'((i[1:0] == 2'b11) ? rc_n : 64 / clk_div(3'(i))));
      wr(offs[i], seed[15:8]);
      rd(offs[i], seed[15:8] & msk[i], "rw");
      wr(offs[i], 8'h00);
    end
    $display("registers done");
    wr(`DCV_OFF_SEC2, 8'h7f);
    chk("con off", 16'(sec_con), 16'h0000);
    chk("pin_direction off", 16'(sec_pin_direction), 16'h0000);
    wr(`DCV_OFF_CTRL2, 8'h01);
    chk("enable", 16'(conv_en), 16'h0002);
    for (int k = 0; k < 7; k++)
    begin
      @(posedge clock);
      pri_ch2 <= 5'h14 + 5'(k);
      @(posedge clock);
      #1;
      chk("con", 16'(sec_con), 16'(7'h7f & ~(7'h01 << k)));
      chk("pin_direction", 16'(sec_pin_direction), 16'h007f);
    end
    @(posedge clock);
    pri_ch2 <= 5'h00;
    $display("secondary done");
    wr(`DCV_OFF_PRE2, 8'h01);
    wr(`DCV_OFF_POL2, 8'hc3);
    wr(`DCV_OFF_COMMON, 8'h80);
    wr(`DCV_OFF_CTRL2, 8'h03);
    wait_for(2, DCV_PRE, 1'b0);
    chk("pol a", 16'({an2.ext_pol, an2.int_pol, an2.guard_pol}), 16'h0007);
    chk("bias", 16'(sec_pre), 16'h007f);
    wait_for(2, DCV_PRE, 1'b1);
    chk("pol b", 16'({an2.ext_pol, an2.int_pol, an2.guard_pol}), 16'h0000);
    rd(`DCV_OFF_STAT, 8'h50, "stat");
    rd(`DCV_OFF_COMMON, 8'h84, "go all");
    rd(`DCV_OFF_POL2, 8'hc3, "pol kept");
    rd(`DCV_OFF_CTRL2, 8'h03, "busy");
    wait_for(2, DCV_IDLE, 1'b0);
    rd(`DCV_OFF_CTRL2, 8'h01, "done");
    rd(`DCV_OFF_STAT, 8'h00, "stat idle");
    rd(`DCV_OFF_RES2H, {6'h00, RES_B[9:8]}, "res hi");
    rd(`DCV_OFF_RES2L, RES_B[7:0], "res lo");
    $display("double sample done");
    wr(`DCV_OFF_CTRL2, 8'h00);
    wr(`DCV_OFF_CTRL1, 8'h01);
    chk("enable", 16'(conv_en), 16'h0001);
    wr(`DCV_OFF_POL1, 8'hc2);
    wr(`DCV_OFF_COMMON, 8'h04);
    wait_for(1, DCV_ACQ, 1'b0);
    chk("no pre", 16'(waited <= 3), 16'h0001);
    chk("sync off", 16'(an2.stage), 16'(DCV_IDLE));
    chk("no inv", 16'({an1.ext_pol, an1.int_pol, an1.guard_pol}), 16'h0006);
    rd(`DCV_OFF_COMMON, 8'h04, "go all");
    wait_for(1, DCV_IDLE, 1'b0);
    rd(`DCV_OFF_COMMON, 8'h00, "go clr");
    rd(`DCV_OFF_RES1H, RES_A[9:2], "res hi");
    rd(`DCV_OFF_RES1L, {RES_A[1:0], 6'h00}, "res lo");
    $display("sync start done");
    wr(`DCV_OFF_PRE1, 8'h05);
    for (int c = 0; c < 8; c++)
    begin
      wr(`DCV_OFF_TRIG1, {1'b0, 3'(c), 4'h0});
      for (int s = 0; s < 5; s++)
        if (s != c - 3)
          fire(s);
      repeat (4) @(posedge clock);
      #1;
      chk("no trig", 16'(an1.stage), 16'(DCV_IDLE));
      if (c >= 3)
      begin
        fire(c - 3);
        wait_for(1, DCV_PRE, 1'b0);
        wr(`DCV_OFF_CTRL1, 8'h01);
        wait_for(1, DCV_IDLE, 1'b0);
      end
    end
    $display("triggers done");
    tally_and_finish();
  end
endmodule : dcv_ctrl_tb_top
`default_nettype wire
